// file: hw/spra_pkg.sv
// constants for the special-purpose register access block
// assumes one command clock shared by the controller and the device
package spra_pkg;
  // burst shape
  localparam int LOC_W = 8;
  localparam int LANES = 8;
  localparam int UIS = 8;
  localparam int LAT_W = 7;
  // command decode, {ras_n, cas_n, we_n} with act_n high
  typedef enum logic [2:0] {
    SPRA_CMD_MRS = 3'h0,
    SPRA_CMD_REF = 3'h1,
    SPRA_CMD_PRE = 3'h2,
    SPRA_CMD_WR = 3'h4,
    SPRA_CMD_RD = 3'h5,
    SPRA_CMD_NOP = 3'h7
  } spra_cmd_e;
  // mode register three select and field positions
  localparam logic [1:0] MODE3_BG = 2'h0;
  localparam logic [1:0] MODE3_BA = 2'h3;
  localparam int MODE3_FMT_HI = 12;
  localparam int MODE3_FMT_LO = 11;
  localparam int MODE3_GEAR = 3;
  localparam int MODE3_EN = 2;
  localparam int MODE3_PAGE_HI = 1;
  localparam int AUTO_PRE_BIT = 10;
  typedef enum logic [1:0] {
    SPRA_FMT_SERIAL = 2'h0,
    SPRA_FMT_PARALLEL = 2'h1,
    SPRA_FMT_STAGGER = 2'h2,
    SPRA_FMT_RSVD = 2'h3
  } spra_fmt_e;
  localparam logic [1:0] PAGE_PATTERN = 2'h0;
  localparam logic [1:0] PAGE_ERROR = 2'h1;
  localparam logic [1:0] PAGE_MIRROR = 2'h2;
  // pattern page reset values
  localparam logic [7:0] PAT0_RST = 8'h55;
  localparam logic [7:0] PAT1_RST = 8'h33;
  localparam logic [7:0] PAT2_RST = 8'h0F;
  localparam logic [7:0] PAT3_RST = 8'h00;
  // vendor page contents; values are arbitrary
  localparam logic [7:0] VENDOR0 = 8'h00;
  localparam logic [7:0] VENDOR1 = 8'h00;
  localparam logic [7:0] VENDOR2 = 8'h00;
  localparam logic [7:0] VENDOR3 = 8'h00;
endpackage

// file: hw/spra_burst_if.sv
// carries one read burst request and its serialized answer
// assumes both ends run on ref_clk
`timescale 1ns/10ps
interface spra_burst_if;
  logic start;
  logic [spra_pkg::LAT_W-1:0] latency;
  logic [spra_pkg::UIS-1:0][spra_pkg::LANES-1:0] ui_word;
  logic [spra_pkg::LANES-1:0] dq;
  logic dq_valid;
  modport src (output start, latency, ui_word, input dq, dq_valid);
  modport burst (input start, latency, ui_word, output dq, dq_valid);
endinterface

// file: hw/spra_burst.sv
// read latency counter and eight-beat output serializer
// assumes start is a one-cycle pulse on ref_clk; busy starts are dropped
`timescale 1ns/10ps
module spra_burst (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic clk_en,
  // request and answer
  spra_burst_if.burst bus
);
  typedef enum logic [1:0] {
    SPRA_B_IDLE = 2'h0,
    SPRA_B_WAIT = 2'h1,
    SPRA_B_SEND = 2'h2
  } spra_bst_e;

  typedef struct packed {
    spra_bst_e st;
    logic [spra_pkg::LAT_W-1:0] cnt;
    logic [2:0] ui;
    logic [spra_pkg::UIS-1:0][spra_pkg::LANES-1:0] words;
    logic [spra_pkg::LANES-1:0] dq;
    logic valid;
  } spra_bst_s;

  spra_bst_s q, d;

  always_comb begin
    d = q;
    case (q.st)
      SPRA_B_IDLE: begin
        d.valid = 1'b0;
        if (bus.start) begin
          d.words = bus.ui_word;
          d.cnt = bus.latency;
          d.st = SPRA_B_WAIT;
        end
      end
      SPRA_B_WAIT: begin
        // data leaves exactly latency edges after the command edge, or one edge when latency is zero
        if (q.cnt <= 7'h01) begin // RULE_21
          d.dq = q.words[0];
          d.valid = 1'b1;
          d.ui = 3'h1;
          d.st = SPRA_B_SEND;
        end else begin
          d.cnt = q.cnt - 7'h01;
        end
      end
      SPRA_B_SEND: begin
        if (q.ui == 3'h0) begin
          d.valid = 1'b0;
          d.st = SPRA_B_IDLE;
        end else begin
          d.dq = q.words[q.ui];
          d.ui = q.ui + 3'h1;
        end
      end
      default: d.st = SPRA_B_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      q <= '0;
    end else if (clk_en) begin
      q <= d;
    end
  end

  assign bus.dq = q.dq;
  assign bus.dq_valid = q.valid;
endmodule

// file: hw/spra_top.sv
// special-purpose register access mode of a memory device
// assumes the command pins are driven from logic on ref_clk, one beat
// of data per ref_clk cycle instead of per clock edge
//
// Functional notes
// (RULE_01) four pages of four byte locations
// (RULE_02) pages 1 to 3 read in serial only
// (RULE_03) page 3 is vendor use, not relied on
// (RULE_04) no bus inversion on these reads
// (RULE_05) only listed commands while access enabled
// (RULE_06) auto precharge ignored while access enabled
// (RULE_07) no power-down or self refresh then
// (RULE_08) wait refresh cycle time after refresh
// (RULE_09) single-rate refresh only in this mode
// (RULE_10) finish sequences before any refresh
// (RULE_11) format field: serial, parallel, staggered
// (RULE_12) enable bit routes reads and writes here
// (RULE_13) page field selects one of four pages
// (RULE_14) bit 7 is address 7 and first beat
// (RULE_15) page 1 holds captured failing command frame
// (RULE_16) page 2 mirrors mode register settings
// (RULE_17) temperature status reports refresh rate need
// (RULE_18) mode set only by mode register writes
// (RULE_19) writes to pages 1 to 3 ignored
// (RULE_20) pattern page resets to defaults, keeps writes
// (RULE_21) read data bursts after additive plus CAS
// (RULE_22) recovery wait before leaving the mode
`timescale 1ns/10ps
module spra_top (
  // clock, reset, enable
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic clk_en,
  // command and address bus
  input wire logic cs_n,
  input wire logic act_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [1:0] bg,
  input wire logic [1:0] ba,
  input wire logic [17:0] addr,
  input wire logic par,
  // latency settings in cycles
  input wire logic [4:0] additive_latency,
  input wire logic [5:0] cas_latency,
  // settings mirrored on page 2, the parity latency code shown on page 1, and the read inversion setting
  input wire logic hard_repair_support,
  input wire logic soft_repair_support,
  input wire logic [2:0] write_termination,
  input wire logic [1:0] temp_status,
  input wire logic crc_write_enable,
  input wire logic dq_reference_range,
  input wire logic [5:0] dq_reference_level,
  input wire logic [4:0] cas_latency_code,
  input wire logic [2:0] cas_write_latency_code,
  input wire logic [2:0] nominal_termination,
  input wire logic [2:0] parity_latency_code,
  input wire logic read_dbi_setting,
  // error events
  input wire logic ca_parity_error,
  input wire logic crc_error,
  input wire logic error_status_clear,
  // read data and status
  output logic [7:0] dq_out,
  output logic dq_valid,
  output logic read_dbi_active,
  output logic access_active,
  output logic [1:0] read_format,
  output logic [1:0] active_page,
  // normal core path
  output logic core_access,
  output logic core_precharge
);
  typedef struct packed {
    logic en;
    logic [1:0] fmt;
    logic [1:0] page;
    logic gear;
    logic [3:0][7:0] pattern;
    logic [2:0][7:0] frame;
    logic crc_err;
    logic par_err;
    logic dbi;
    logic core_acc;
    logic core_pre;
  } spra_state_s;

  spra_state_s q, d;
  spra_burst_if bus ();

  logic cmd_valid;
  logic [2:0] cmd;
  logic rd_hit;
  logic wr_hit;
  logic [3:0][7:0] page_err;
  logic [3:0][7:0] page_mir;
  logic [3:0][7:0] page_ven;
  logic [3:0][7:0] sel_page;
  logic [1:0] eff_fmt;

  assign cmd_valid = ~cs_n & act_n;
  assign cmd = {ras_n, cas_n, we_n};
  // reads and writes are routed here only while enabled
  assign rd_hit = cmd_valid && q.en
    && cmd == spra_pkg::SPRA_CMD_RD; // RULE_12
  assign wr_hit = cmd_valid && q.en
    && cmd == spra_pkg::SPRA_CMD_WR; // RULE_12

  // page 1: captured frame plus error status
  always_comb begin
    page_err[0] = q.frame[0]; // RULE_15
    page_err[1] = q.frame[1]; // RULE_15
    page_err[2] = q.frame[2]; // RULE_15
    page_err[3] = {q.crc_err, q.par_err, parity_latency_code, 3'h0};
  end

  // page 2: live mirrors of the inputs plus the registered gear bit, so always current
  always_comb begin
    page_mir[0] = {hard_repair_support, soft_repair_support,
      write_termination[2], temp_status, crc_write_enable,
      write_termination[1:0]}; // RULE_16 RULE_17
    page_mir[1] = {dq_reference_range, dq_reference_level,
      q.gear}; // RULE_16
    page_mir[2] = {cas_latency_code, cas_write_latency_code}; // RULE_16
    page_mir[3] = {nominal_termination, 5'h00}; // RULE_16
  end

  always_comb begin
    page_ven[0] = spra_pkg::VENDOR0;
    page_ven[1] = spra_pkg::VENDOR1;
    page_ven[2] = spra_pkg::VENDOR2;
    page_ven[3] = spra_pkg::VENDOR3;
  end

  // page select for reads
  always_comb begin
    case (q.page) // RULE_13 RULE_01
      spra_pkg::PAGE_PATTERN: sel_page = q.pattern;
      spra_pkg::PAGE_ERROR: sel_page = page_err;
      spra_pkg::PAGE_MIRROR: sel_page = page_mir;
      default: sel_page = page_ven;
    endcase
  end

  // non-pattern pages and the reserved code fall back to serial
  always_comb begin
    if (q.page != spra_pkg::PAGE_PATTERN) begin
      eff_fmt = spra_pkg::SPRA_FMT_SERIAL; // RULE_02
    end else if (q.fmt == spra_pkg::SPRA_FMT_RSVD) begin
      eff_fmt = spra_pkg::SPRA_FMT_SERIAL; // RULE_11
    end else begin
      eff_fmt = q.fmt; // RULE_11
    end
  end

  // in serial and staggered, beat u carries bit 7-u (parallel puts bit 7-l on lane l); the staggered lanes walk the locations
  always_comb begin
    logic [1:0] lane_loc;
    lane_loc = 2'h0;
    for (int u = 0; u < spra_pkg::UIS; u++) begin
      for (int l = 0; l < spra_pkg::LANES; l++) begin
        lane_loc = ba + l[1:0];
        case (eff_fmt)
          spra_pkg::SPRA_FMT_PARALLEL:
            bus.ui_word[u][l] = sel_page[ba][7-l];
          spra_pkg::SPRA_FMT_STAGGER:
            bus.ui_word[u][l] = sel_page[lane_loc][7-u]; // RULE_14
          default:
            bus.ui_word[u][l] = sel_page[ba][7-u]; // RULE_14
        endcase
      end
    end
  end

  assign bus.start = rd_hit;
  assign bus.latency = 7'(additive_latency) + 7'(cas_latency); // RULE_21

  spra_burst u_burst (
    .ref_clk(ref_clk),
    .reset(reset),
    .clk_en(clk_en),
    .bus(bus)
  );

  always_comb begin
    d = q;
    d.core_acc = 1'b0;
    d.core_pre = 1'b0;
    // mode fields change only through a write to mode register three
    if (cmd_valid && cmd == spra_pkg::SPRA_CMD_MRS
        && bg == spra_pkg::MODE3_BG && ba == spra_pkg::MODE3_BA) begin
      d.en = addr[spra_pkg::MODE3_EN]; // RULE_18 RULE_12
      d.fmt = addr[spra_pkg::MODE3_FMT_HI:spra_pkg::MODE3_FMT_LO]; // RULE_11
      d.page = addr[spra_pkg::MODE3_PAGE_HI:0]; // RULE_13
      d.gear = addr[spra_pkg::MODE3_GEAR];
    end
    // only the pattern page takes writes
    if (wr_hit && q.page == spra_pkg::PAGE_PATTERN) begin // RULE_19
      d.pattern[ba] = addr[7:0]; // RULE_14 RULE_20
    end
    // outside the mode, commands go to the core as usual
    if (cmd_valid && !q.en && (cmd == spra_pkg::SPRA_CMD_RD // RULE_06
        || cmd == spra_pkg::SPRA_CMD_WR)) begin
      d.core_acc = 1'b1;
      d.core_pre = addr[spra_pkg::AUTO_PRE_BIT];
    end
    // in the mode the auto-precharge bit is simply not looked at
    // RULE_06 holds because both pulses need the mode off
    d.dbi = read_dbi_setting & ~d.en; // RULE_04
    // first error frame is kept until cleared; a new event beats clear
    if (error_status_clear) begin
      d.par_err = 1'b0;
      d.crc_err = 1'b0;
    end
    if (ca_parity_error && !q.par_err) begin
      d.frame[0] = addr[7:0]; // RULE_15
      d.frame[1] = {cas_n, we_n, addr[13:8]}; // RULE_15
      d.frame[2] = {par, act_n, bg[1], bg[0], ba[1], ba[0],
        addr[17], ras_n}; // RULE_15
    end
    if (ca_parity_error) begin
      d.par_err = 1'b1;
    end
    if (crc_error) begin
      d.crc_err = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      q <= '0;
      q.pattern <= {spra_pkg::PAT3_RST, spra_pkg::PAT2_RST,
        spra_pkg::PAT1_RST, spra_pkg::PAT0_RST}; // RULE_20
    end else if (clk_en) begin
      q <= d;
    end
  end

  assign dq_out = bus.dq;
  assign dq_valid = bus.dq_valid;
  assign read_dbi_active = q.dbi;
  assign access_active = q.en;
  assign read_format = q.fmt;
  assign active_page = q.page;
  assign core_access = q.core_acc;
  assign core_precharge = q.core_pre;
endmodule

// file: verif/spra_top_assertions.sv
// assertions on the special-purpose register access block
// assumes one clock; bound onto spra_top
`timescale 1ns/10ps
module spra_top_chk (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic clk_en,
  // command bus
  input wire logic cs_n,
  input wire logic act_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [1:0] bg,
  input wire logic [1:0] ba,
  input wire logic [17:0] addr,
  input wire logic [4:0] additive_latency,
  input wire logic [5:0] cas_latency,
  // outputs
  input wire logic [7:0] dq_out,
  input wire logic dq_valid,
  input wire logic read_dbi_active,
  input wire logic access_active,
  input wire logic [1:0] read_format,
  input wire logic [1:0] active_page,
  input wire logic core_access,
  input wire logic core_precharge
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  logic cmd, mrs, rdwr;
  logic [6:0] rl, cnt_q, cnt_d;
  assign cmd = clk_en && !cs_n && act_n;
  assign mrs = cmd && {ras_n, cas_n, we_n} == 3'h0 && {bg, ba} == 4'h3;
  assign rdwr = cmd && ras_n && !cas_n;
  assign rl = 7'(additive_latency) + 7'(cas_latency);
  // pins the first beat to the exact read latency
  always_comb begin
    cnt_d = (cnt_q != 7'h00 && clk_en) ? cnt_q - 7'h01 : cnt_q;
    if (rdwr && we_n && access_active && cnt_q == 7'h00 && !dq_valid)
      cnt_d = (rl < 7'h02) ? 7'h01 : rl;
  end
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset)
      cnt_q <= 7'h00;
    else
      cnt_q <= cnt_d;
  end
  mode_en_a:
    assert property (mrs |=> access_active == $past(addr[2]))
    else $error("enable bit not taken");
  page_sel_a:
    assert property (mrs |=> active_page == $past(addr[1:0]))
    else $error("page field not taken");
  fmt_sel_a:
    assert property (mrs |=> read_format == $past(addr[12:11]))
    else $error("format field not taken");
  no_inversion_a:
    assert property (access_active |-> !read_dbi_active)
    else $error("inversion active in mode");
  no_core_a:
    assert property (access_active && rdwr |=> !core_access && !core_precharge)
    else $error("core touched in mode");
  core_pass_a:
    assert property (!access_active && rdwr |=>
      core_access && core_precharge == $past(addr[10]))
    else $error("normal access lost");
  read_lat_a:
    assert property (cnt_q == 7'h01 |=> $rose(dq_valid))
    else $error("burst latency wrong");
  burst_len_a:
    assert property ($rose(dq_valid) |-> dq_valid [*8] ##1 !dq_valid)
    else $error("burst length wrong");
  serial_only_a:
    assert property (dq_valid && (active_page != 2'h0 || read_format == 2'h3)
      |-> dq_out == 8'h00 || dq_out == 8'hFF)
    else $error("lanes differ in serial");
  cover property (mrs && addr[2]);
  cover property ($rose(dq_valid));
  cover property (core_precharge);
endmodule
bind spra_top spra_top_chk chk (.ref_clk(ref_clk), .reset(reset),
  .clk_en(clk_en), .cs_n(cs_n), .act_n(act_n), .ras_n(ras_n),
  .cas_n(cas_n), .we_n(we_n), .bg(bg), .ba(ba), .addr(addr),
  .additive_latency(additive_latency), .cas_latency(cas_latency),
  .dq_out(dq_out), .dq_valid(dq_valid), .read_dbi_active(read_dbi_active),
  .access_active(access_active), .read_format(read_format),
  .active_page(active_page), .core_access(core_access),
  .core_precharge(core_precharge));

// file: verif/spra_ctl.sv
// controller model driving the command bus of the register block
// assumes each command starts on a falling edge of ref_clk
`timescale 1ns/10ps
module spra_ctl (
  // clock
  input wire logic ref_clk,
  // command bus
  output logic cs_n,
  output logic act_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic [1:0] bg,
  output logic [1:0] ba,
  output logic [17:0] addr,
  output logic par
);
  initial begin
    cs_n = 1'b1;
    act_n = 1'b1;
    {ras_n, cas_n, we_n} = 3'h7;
    {bg, ba, addr, par} = 23'h0;
  end
  // never refreshes or powers down, so no refresh spacing arises
  task automatic cmd(input logic [2:0] c, input logic [1:0] g, b,
    input logic [17:0] a);
    cs_n = 1'b0;
    act_n = 1'b1;
    {ras_n, cas_n, we_n} = c;
    {bg, ba, addr} = {g, b, a};
    par = ^{c, g, b, a};
    @(negedge ref_clk);
    // a deselected bus shows garbage, not the last command
    cs_n = 1'b1;
    {ras_n, cas_n, we_n} = ~c;
    {ba, addr} = ~{b, a};
    // one idle edge keeps back-to-back calls off the same time step
    @(negedge ref_clk);
  endtask
endmodule

// file: verif/spra_top_test.sv
// self-checking bench for the special-purpose register access block
// assumes spra_ctl drives every command pin
`timescale 1ns/10ps
module spra_top_test;
  logic ref_clk = 1'b0, reset = 1'b1, err = 1'b0, dbs = 1'b1, crc = 1'b0;
  logic cs_n, act_n, ras_n, cas_n, we_n, par, dq_valid, dbi, act, cac, cpr;
  logic [1:0] bg, ba, fmt, pg;
  logic [17:0] addr;
  logic [4:0] al = 5'h02;
  logic [5:0] cl = 6'h05;
  logic [2:0] plc = 3'h5;
  logic [7:0] dq_out, m0 = 8'hAA, m1 = 8'hD5, m2 = 8'h9E, m3 = 8'hA0;
  logic [7:0] loc [4];
  int bad_count = 0, n_checks = 0;
  always #5 ref_clk = ~ref_clk;
  spra_ctl ctl (.ref_clk(ref_clk), .cs_n(cs_n), .act_n(act_n), .ras_n(ras_n),
    .cas_n(cas_n), .we_n(we_n), .bg(bg), .ba(ba), .addr(addr), .par(par));
  spra_top DUT (.ref_clk(ref_clk), .reset(reset), .clk_en(1'b1),
    .cs_n(cs_n), .act_n(act_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
    .bg(bg), .ba(ba), .addr(addr), .par(par), .additive_latency(al),
    .cas_latency(cl), .hard_repair_support(m0[7]),
    .soft_repair_support(m0[6]), .write_termination({m0[5], m0[1:0]}),
    .temp_status(m0[4:3]), .crc_write_enable(m0[2]),
    .dq_reference_range(m1[7]), .dq_reference_level(m1[6:1]),
    .cas_latency_code(m2[7:3]), .cas_write_latency_code(m2[2:0]),
    .nominal_termination(m3[7:5]), .parity_latency_code(plc),
    .read_dbi_setting(dbs), .ca_parity_error(err), .crc_error(crc),
    .error_status_clear(1'b0), .dq_out(dq_out), .dq_valid(dq_valid),
    .read_dbi_active(dbi), .access_active(act), .read_format(fmt),
    .active_page(pg), .core_access(cac), .core_precharge(cpr));
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] beat(input logic [1:0] f, b, input int k);
    for (int i = 0; i < 8; i++)
      case (f)
        2'h1: beat[i] = loc[b][7-i];
        2'h2: beat[i] = loc[(b+i)%4][7-k];
        default: beat[i] = loc[b][7-k];
      endcase
  endfunction
  task automatic rd(input logic [1:0] b, f);
    int n;
    ctl.cmd(3'h5, 2'h0, b, 18'h0);
    n = 1;
    while (dq_valid !== 1'b1 && n < 40) begin
      @(negedge ref_clk);
      n++;
    end
    chk(8'(n), 8'(al + cl));
    if (n == 40)
      end_sim();
    for (int k = 0; k < 8; k++) begin
      chk(dq_out, beat(f, b, k));
      @(negedge ref_clk);
    end
    chk({7'h0, dq_valid}, 8'h00);
    @(negedge ref_clk);
  endtask
  task automatic t_defaults;
    ctl.cmd(3'h0, 2'h0, 2'h3, 18'h00004);
    loc = '{8'h55, 8'h33, 8'h0F, 8'h00};
    for (int b = 0; b < 4; b++)
      rd(2'(b), 2'h0);
    $display("defaults done");
  endtask
  task automatic t_formats;
    ctl.cmd(3'h4, 2'h0, 2'h1, 18'h000A5);
    fork
      ctl.cmd(3'h4, 2'h0, 2'h2, 18'h0043C);
      begin
        // the core pulse would stand only in the cycle after the command
        @(negedge ref_clk);
        chk({6'h0, cac, cpr}, 8'h00);
      end
    join
    loc[1] = 8'hA5;
    loc[2] = 8'h3C;
    for (int f = 0; f < 4; f++) begin
      ctl.cmd(3'h0, 2'h0, 2'h3, {5'h0, 2'(f), 11'h004});
      rd(2'h1, 2'(f));
    end
    $display("formats done");
  endtask
  task automatic t_pages;
    err = 1'b1;
    crc = 1'b1;
    ctl.cmd(3'h7, 2'h0, 2'h0, 18'h0005A);
    err = 1'b0;
    crc = 1'b0;
    ctl.cmd(3'h0, 2'h0, 2'h3, 18'h0080E);
    ctl.cmd(3'h4, 2'h0, 2'h1, 18'h00000);
    loc = '{m0, m1, m2, m3};
    for (int b = 0; b < 4; b++)
      rd(2'(b), 2'h0);
    ctl.cmd(3'h0, 2'h0, 2'h3, 18'h00005);
    // frame of the idle command at the error pulse; its parity bit is 1
    loc = '{8'h5A, 8'hC0, 8'hC1, {2'h3, plc, 3'h0}};
    for (int b = 0; b < 4; b++)
      rd(2'(b), 2'h0);
    ctl.cmd(3'h0, 2'h0, 2'h3, 18'h00004);
    loc = '{8'h55, 8'hA5, 8'h3C, 8'h00};
    rd(2'h1, 2'h0);
    $display("pages done");
  endtask
  task automatic t_normal;
    ctl.cmd(3'h0, 2'h0, 2'h3, 18'h00000);
    fork
      ctl.cmd(3'h5, 2'h0, 2'h0, 18'h00400);
      begin
        @(negedge ref_clk);
        chk({6'h0, cac, cpr}, 8'h03);
      end
    join
    chk({7'h0, dbi}, 8'h01);
    $display("normal done");
  endtask
  initial begin
    repeat (12) @(negedge ref_clk);
    reset = 1'b0;
    @(negedge ref_clk);
    t_defaults();
    t_formats();
    t_pages();
    t_normal();
    end_sim();
  end
endmodule
